// ===== rtl/dtc_consts.svh
// Constants of the dual timer/counter block: register offsets, bit positions,
// reset values and clock divide ratios.
// Assumes inclusion by bare name from the rtl folder.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

`define DTC_ADDR_TIMER_CONTROL_STATUS      8'h88
`define DTC_ADDR_TIMER_MODE_CONFIG      8'h89
`define DTC_ADDR_TL0       8'h8a
`define DTC_ADDR_TL1       8'h8b
`define DTC_ADDR_TH0       8'h8c
`define DTC_ADDR_TH1       8'h8d
`define DTC_ADDR_CLOCK_DIVIDE_CONFIG     8'h8e

`define DTC_RST_TIMER_CONTROL_STATUS       8'h00
`define DTC_RST_TIMER_MODE_CONFIG       8'h00
`define DTC_RST_COUNT      8'h00
`define DTC_RST_CLOCK_DIVIDE_CONFIG      8'h01
`define DTC_CLOCK_DIVIDE_CONFIG_MASK     8'h3f
`define DTC_READ_UNMAPPED  8'h00

// Control/status byte
`define DTC_TC_T1_OVF      7
`define DTC_TC_T1_RUN      6
`define DTC_TC_T0_OVF      5
`define DTC_TC_T0_RUN      4
`define DTC_TC_XB_FLAG     3
`define DTC_TC_XB_TYPE     2
`define DTC_TC_XA_FLAG     1
`define DTC_TC_XA_TYPE     0

// Mode byte: timer 1 in the upper nibble, timer 0 in the lower
`define DTC_TM_T1_GATE     7
`define DTC_TM_T1_SRC      6
`define DTC_TM_T1_MODE_HI  5
`define DTC_TM_T1_MODE_LO  4
`define DTC_TM_T0_GATE     3
`define DTC_TM_T0_SRC      2
`define DTC_TM_T0_MODE_HI  1
`define DTC_TM_T0_MODE_LO  0

// Clock divide select byte
`define DTC_CK_T2_DIV      5
`define DTC_CK_T1_DIV      4
`define DTC_CK_T0_DIV      3

`define DTC_DIV_SLOW       12
`define DTC_DIV_FAST       4
`define DTC_DIV_CNT_W      4
`define DTC_PRESCALE_W     5

`endif

// ===== rtl/dtc_div.sv
// Free-running divider giving slow and fast timer tick enables.
// Assumes one system clock; the ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module dtc_div
	import dtc_pkg::*;
#(
	parameter int DIV_SLOW = `DTC_DIV_SLOW,
	parameter int DIV_FAST = `DTC_DIV_FAST
) (
	input  wire logic mclk,
	input  wire logic rst,
	output logic      tick_slow,
	output logic      tick_fast
);

	initial begin
		if (DIV_FAST < 2 || DIV_SLOW % DIV_FAST != 0 || DIV_SLOW > (1 << `DTC_DIV_CNT_W)) begin
			$error("dtc_div: divide ratios not supported");
		end
	end

	localparam logic [`DTC_DIV_CNT_W-1:0] LAST = `DTC_DIV_CNT_W'(DIV_SLOW - 1);
	localparam logic [`DTC_DIV_CNT_W-1:0] FMOD = `DTC_DIV_CNT_W'(DIV_FAST - 1);

	dtc_div_st_t st;
	dtc_div_st_t next_st;

	// Runs on its own so instruction timing never depends on the selects
	always_comb begin
		next_st.cnt       = (st.cnt == LAST) ? '0 : st.cnt + 1'b1;  // RULE15
		next_st.tick_slow = (st.cnt == LAST);
		next_st.tick_fast = ((st.cnt % `DTC_DIV_CNT_W'(DIV_FAST)) == FMOD);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick_slow = st.tick_slow;
	assign tick_fast = st.tick_fast;

	property p_fast_spacing;
		@(posedge mclk) disable iff (rst)
		st.tick_fast |=> !st.tick_fast [*3] ##1 st.tick_fast;
	endproperty
	a_fast_spacing: assert property (p_fast_spacing) else $error("fast tick spacing wrong");  // RULE13

	property p_slow_in_fast;
		@(posedge mclk) disable iff (rst)
		st.tick_slow |-> st.tick_fast;
	endproperty
	a_slow_in_fast: assert property (p_slow_in_fast) else $error("slow tick off the fast grid");  // RULE15

endmodule : dtc_div

`default_nettype wire

// ===== rtl/dtc_edge.sv
// Pin sampler with falling edge detection for count and interrupt pins.
// Assumes the pin is already synchronous to MCLK.
`timescale 1ns/1ps
`default_nettype none

module dtc_edge
	import dtc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      fall
);

	dtc_edge_st_t st;
	dtc_edge_st_t next_st;

	always_comb begin
		next_st.cur  = pin;
		next_st.prev = st.cur;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st <= '{cur: 1'b1, prev: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	// Both terms come from flops so a one-cycle glitch still needs a full low cycle
	assign level = st.cur;
	assign fall  = st.prev & ~st.cur;  // RULE17

endmodule : dtc_edge

`default_nettype wire

// ===== rtl/dtc_pkg.sv
// Types shared by the dual timer/counter block.
// Assumes dtc_consts.svh sits beside it.
`include "dtc_consts.svh"

package dtc_pkg;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT  = 2'b00,
		DTC_MODE_16BIT  = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT  = 2'b11
	} dtc_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dtc_sfr_req_t;

	typedef struct packed {
		logic cur;
		logic prev;
	} dtc_edge_st_t;

	typedef struct packed {
		logic [`DTC_DIV_CNT_W-1:0] cnt;
		logic                      tick_slow;
		logic                      tick_fast;
	} dtc_div_st_t;

	typedef struct packed {
		logic [7:0] timer_control_status;
		logic [7:0] timer_mode_config;
		logic [7:0] tl0;
		logic [7:0] tl1;
		logic [7:0] th0;
		logic [7:0] th1;
		logic [7:0] clock_divide_config;
		logic [7:0] rdata;
		logic       t2_tick;
	} dtc_state_t;

endpackage : dtc_pkg

// ===== rtl/dtc_timer.sv
// Dual 16-bit timer/counter with external interrupt flags and clock selects.
// Assumes a byte-wide special register port with one-cycle read and write
// strobes, acknowledge pulses from the interrupt controller when it vectors,
// and pins that are already synchronous to MCLK.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: Overflow sets timer flag; software or interrupt vectoring clears it.
// RULE2: Run bit set counts; cleared halts and holds both count bytes. In mode 3 the timer 0 high byte runs on the timer 1 run bit instead.
// RULE3: Edge mode: falling edge sets request flag until software or vectoring clears.
// RULE4: Level mode: request flag shows inverse of interrupt pin level.
// RULE5: Type bit 0 selects level, 1 selects edge triggering.
// RULE6: Gate bit 1 additionally requires interrupt pin high to count.
// RULE7: Source bit picks divided clock (0) or count pin pulses (1).
// RULE8: Mode bits 00 13-bit, 01 16-bit, 10 8-bit auto reload.
// RULE9: Timer 1 in mode 3 stops and keeps its count.
// RULE10: Timer 0 in mode 3 runs low and high bytes as separate counters.
// RULE11: Mode byte: timer 1 controls upper nibble, timer 0 lower nibble.
// RULE12: Each count is read and written as low and high byte registers.
// RULE13: Clock select bit: 0 divides by 12, 1 divides by 4.
// RULE14: Timer 2 select ignored in baud generator or clock output mode.
// RULE15: Clock selects change only timer rates, never instruction timing.
// RULE16: Mode 0 uses 5-bit low prescaler; mode 2 reloads low from high.
// RULE17: Count pin sources hold levels long enough for every falling edge.
module dtc_timer
	import dtc_pkg::*;
(
	input  wire logic         MCLK,
	input  wire logic         RST,
	input  wire dtc_sfr_req_t SFR_REQ,
	output logic [7:0]        SFR_RDATA,
	input  wire logic         ACK_TIMER0,
	input  wire logic         ACK_TIMER1,
	input  wire logic         ACK_EXT_A,
	input  wire logic         ACK_EXT_B,
	input  wire logic         EXT_IRQ_A_PIN,
	input  wire logic         EXT_IRQ_B_PIN,
	input  wire logic         TIMER0_PULSE_PIN,
	input  wire logic         TIMER1_PULSE_PIN,
	input  wire logic         TIMER2_SPECIAL_MODE,
	output logic              TIMER0_OVERFLOW_FLAG,
	output logic              TIMER1_OVERFLOW_FLAG,
	output logic              EXT_IRQ_A_FLAG,
	output logic              EXT_IRQ_B_FLAG,
	output logic              TIMER2_TICK
);

	// One increment step: returns {overflow, high, low}
	function automatic logic [16:0] dtc_step(input dtc_mode_t mode, input logic [7:0] lo, input logic [7:0] hi);
		logic [5:0]  pre;
		logic [8:0]  hsum;
		logic [16:0] wsum;
		pre  = {1'b0, lo[`DTC_PRESCALE_W-1:0]} + 6'h01;
		hsum = {1'b0, hi} + 9'h001;
		wsum = {1'b0, hi, lo} + 17'h00001;
		dtc_step = {1'b0, hi, lo};
		unique case (mode)
			DTC_MODE_13BIT: begin
				// Upper three low bits are left alone, only the prescaler runs
				if (pre[`DTC_PRESCALE_W]) begin  // RULE16
					dtc_step = {hsum, lo[7:`DTC_PRESCALE_W], pre[`DTC_PRESCALE_W-1:0]};
				end else begin
					dtc_step = {1'b0, hi, lo[7:`DTC_PRESCALE_W], pre[`DTC_PRESCALE_W-1:0]};
				end
			end
			DTC_MODE_16BIT: begin
				dtc_step = wsum;  // RULE8
			end
			DTC_MODE_RELOAD: begin
				if (lo == 8'hff) begin
					dtc_step = {1'b1, hi, hi};  // RULE16
				end else begin
					dtc_step = {1'b0, hi, 8'(lo + 8'h01)};
				end
			end
			DTC_MODE_SPLIT: begin
				dtc_step = {1'b0, hi, lo};
			end
		endcase
	endfunction : dtc_step

	dtc_state_t st;
	dtc_state_t next_st;

	logic tick_slow;
	logic tick_fast;
	logic xa_level;
	logic xa_fall;
	logic xb_level;
	logic xb_fall;
	logic p0_fall;
	logic p1_fall;

	dtc_div u_div (
		.mclk      (MCLK),
		.rst       (RST),
		.tick_slow (tick_slow),
		.tick_fast (tick_fast)
	);

	dtc_edge u_edge_xa (.mclk(MCLK), .rst(RST), .pin(EXT_IRQ_A_PIN), .level(xa_level), .fall(xa_fall));
	dtc_edge u_edge_xb (.mclk(MCLK), .rst(RST), .pin(EXT_IRQ_B_PIN), .level(xb_level), .fall(xb_fall));
	dtc_edge u_edge_p0 (.mclk(MCLK), .rst(RST), .pin(TIMER0_PULSE_PIN), .level(), .fall(p0_fall));
	dtc_edge u_edge_p1 (.mclk(MCLK), .rst(RST), .pin(TIMER1_PULSE_PIN), .level(), .fall(p1_fall));

	dtc_mode_t mode0;
	dtc_mode_t mode1;
	logic      split0;
	logic      tick0;
	logic      tick1;
	logic      en0;
	logic      en1;
	logic      en0_high;
	logic      wr_timer_control_status;
	logic      wr_tl0;
	logic      wr_th0;
	logic      wr_tl1;
	logic      wr_th1;
	logic      ovf0_ev;
	logic      ovf1_ev;
	logic [16:0] step0;
	logic [16:0] step1;
	logic [8:0]  high0_sum;

	always_comb begin
		mode0  = dtc_mode_t'(st.timer_mode_config[`DTC_TM_T0_MODE_HI:`DTC_TM_T0_MODE_LO]);  // RULE11
		mode1  = dtc_mode_t'(st.timer_mode_config[`DTC_TM_T1_MODE_HI:`DTC_TM_T1_MODE_LO]);  // RULE11
		split0 = (mode0 == DTC_MODE_SPLIT);

		tick0 = st.clock_divide_config[`DTC_CK_T0_DIV] ? tick_fast : tick_slow;  // RULE13
		tick1 = st.clock_divide_config[`DTC_CK_T1_DIV] ? tick_fast : tick_slow;  // RULE13

		// Gate bit lets the interrupt pin hold the timer off while it is low
		en0 = st.timer_control_status[`DTC_TC_T0_RUN]  // RULE2
			& (~st.timer_mode_config[`DTC_TM_T0_GATE] | xa_level)  // RULE6
			& (st.timer_mode_config[`DTC_TM_T0_SRC] ? p0_fall : tick0);  // RULE7
		en1 = st.timer_control_status[`DTC_TC_T1_RUN]  // RULE2
			& (~st.timer_mode_config[`DTC_TM_T1_GATE] | xb_level)  // RULE6
			& (st.timer_mode_config[`DTC_TM_T1_SRC] ? p1_fall : tick1)  // RULE7
			& (mode1 != DTC_MODE_SPLIT);  // RULE9
		// In split mode the high byte of timer 0 borrows the timer 1 run bit
		en0_high = split0 & st.timer_control_status[`DTC_TC_T1_RUN] & tick0;  // RULE10

		wr_timer_control_status = SFR_REQ.wr & (SFR_REQ.addr == `DTC_ADDR_TIMER_CONTROL_STATUS);
		wr_tl0  = SFR_REQ.wr & (SFR_REQ.addr == `DTC_ADDR_TL0);
		wr_th0  = SFR_REQ.wr & (SFR_REQ.addr == `DTC_ADDR_TH0);
		wr_tl1  = SFR_REQ.wr & (SFR_REQ.addr == `DTC_ADDR_TL1);
		wr_th1  = SFR_REQ.wr & (SFR_REQ.addr == `DTC_ADDR_TH1);

		step0     = dtc_step(split0 ? DTC_MODE_16BIT : mode0, st.tl0, st.th0);
		step1     = dtc_step(mode1, st.tl1, st.th1);
		high0_sum = {1'b0, st.th0} + 9'h001;

		if (split0) begin
			ovf0_ev = en0 & (st.tl0 == 8'hff);  // RULE10
			ovf1_ev = en0_high & high0_sum[8];  // RULE10
		end else begin
			ovf0_ev = en0 & step0[16];  // RULE1
			ovf1_ev = en1 & step1[16];  // RULE1
		end
	end

	always_comb begin
		next_st = st;
		next_st.t2_tick = (st.clock_divide_config[`DTC_CK_T2_DIV] & ~TIMER2_SPECIAL_MODE) ? tick_fast : tick_slow;  // RULE14

		// Counting first, so a software write in the same cycle takes over
		if (split0) begin
			if (en0) begin
				next_st.tl0 = 8'(st.tl0 + 8'h01);  // RULE10
			end
			if (en0_high) begin
				next_st.th0 = high0_sum[7:0];  // RULE10
			end
		end else if (en0) begin
			next_st.th0 = step0[15:8];
			next_st.tl0 = step0[7:0];
		end
		if (en1) begin
			next_st.th1 = step1[15:8];
			next_st.tl1 = step1[7:0];
		end

		if (SFR_REQ.wr) begin
			unique case (SFR_REQ.addr)
				`DTC_ADDR_TIMER_CONTROL_STATUS:  next_st.timer_control_status  = SFR_REQ.wdata;
				`DTC_ADDR_TIMER_MODE_CONFIG:  next_st.timer_mode_config  = SFR_REQ.wdata;  // RULE11
				`DTC_ADDR_TL0:   next_st.tl0   = SFR_REQ.wdata;  // RULE12
				`DTC_ADDR_TL1:   next_st.tl1   = SFR_REQ.wdata;  // RULE12
				`DTC_ADDR_TH0:   next_st.th0   = SFR_REQ.wdata;  // RULE12
				`DTC_ADDR_TH1:   next_st.th1   = SFR_REQ.wdata;  // RULE12
				`DTC_ADDR_CLOCK_DIVIDE_CONFIG: next_st.clock_divide_config = SFR_REQ.wdata & `DTC_CLOCK_DIVIDE_CONFIG_MASK;
				default: ;
			endcase
		end

		// Vectoring clears a flag, but a set in the same cycle wins
		if (ACK_TIMER0) begin
			next_st.timer_control_status[`DTC_TC_T0_OVF] = 1'b0;  // RULE1
		end
		if (ACK_TIMER1) begin
			next_st.timer_control_status[`DTC_TC_T1_OVF] = 1'b0;  // RULE1
		end
		if (ovf0_ev) begin
			next_st.timer_control_status[`DTC_TC_T0_OVF] = 1'b1;  // RULE1
		end
		if (ovf1_ev) begin
			next_st.timer_control_status[`DTC_TC_T1_OVF] = 1'b1;  // RULE1
		end

		// Type bit as it will stand after this cycle decides the flag behaviour
		if (next_st.timer_control_status[`DTC_TC_XA_TYPE]) begin  // RULE5
			if (ACK_EXT_A) begin
				next_st.timer_control_status[`DTC_TC_XA_FLAG] = 1'b0;  // RULE3
			end
			if (xa_fall) begin
				next_st.timer_control_status[`DTC_TC_XA_FLAG] = 1'b1;  // RULE3
			end
		end else begin
			next_st.timer_control_status[`DTC_TC_XA_FLAG] = ~EXT_IRQ_A_PIN;  // RULE4
		end
		if (next_st.timer_control_status[`DTC_TC_XB_TYPE]) begin  // RULE5
			if (ACK_EXT_B) begin
				next_st.timer_control_status[`DTC_TC_XB_FLAG] = 1'b0;  // RULE3
			end
			if (xb_fall) begin
				next_st.timer_control_status[`DTC_TC_XB_FLAG] = 1'b1;  // RULE3
			end
		end else begin
			next_st.timer_control_status[`DTC_TC_XB_FLAG] = ~EXT_IRQ_B_PIN;  // RULE4
		end

		if (SFR_REQ.rd) begin
			unique case (SFR_REQ.addr)
				`DTC_ADDR_TIMER_CONTROL_STATUS:  next_st.rdata = st.timer_control_status;
				`DTC_ADDR_TIMER_MODE_CONFIG:  next_st.rdata = st.timer_mode_config;
				`DTC_ADDR_TL0:   next_st.rdata = st.tl0;  // RULE12
				`DTC_ADDR_TL1:   next_st.rdata = st.tl1;  // RULE12
				`DTC_ADDR_TH0:   next_st.rdata = st.th0;  // RULE12
				`DTC_ADDR_TH1:   next_st.rdata = st.th1;  // RULE12
				`DTC_ADDR_CLOCK_DIVIDE_CONFIG: next_st.rdata = st.clock_divide_config;
				default:         next_st.rdata = `DTC_READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			st       <= '0;
			st.timer_control_status  <= `DTC_RST_TIMER_CONTROL_STATUS;
			st.timer_mode_config  <= `DTC_RST_TIMER_MODE_CONFIG;
			st.tl0   <= `DTC_RST_COUNT;
			st.tl1   <= `DTC_RST_COUNT;
			st.th0   <= `DTC_RST_COUNT;
			st.th1   <= `DTC_RST_COUNT;
			st.clock_divide_config <= `DTC_RST_CLOCK_DIVIDE_CONFIG;
		end else begin
			st <= next_st;
		end
	end

	assign SFR_RDATA            = st.rdata;
	assign TIMER0_OVERFLOW_FLAG = st.timer_control_status[`DTC_TC_T0_OVF];
	assign TIMER1_OVERFLOW_FLAG = st.timer_control_status[`DTC_TC_T1_OVF];
	assign EXT_IRQ_A_FLAG       = st.timer_control_status[`DTC_TC_XA_FLAG];
	assign EXT_IRQ_B_FLAG       = st.timer_control_status[`DTC_TC_XB_FLAG];
	assign TIMER2_TICK          = st.t2_tick;

	property p_ovf0_set;
		@(posedge MCLK) disable iff (RST)
		ovf0_ev |=> TIMER0_OVERFLOW_FLAG;
	endproperty
	a_ovf0_set: assert property (p_ovf0_set) else $error("timer 0 overflow flag not set");  // RULE1

	property p_ovf0_ack;
		@(posedge MCLK) disable iff (RST)
		ACK_TIMER0 && !ovf0_ev && !wr_timer_control_status |=> !TIMER0_OVERFLOW_FLAG;
	endproperty
	a_ovf0_ack: assert property (p_ovf0_ack) else $error("timer 0 flag not cleared on vectoring");  // RULE1

	property p_halt_holds;
		@(posedge MCLK) disable iff (RST)
		!st.timer_control_status[`DTC_TC_T0_RUN] && !split0 && !wr_tl0 && !wr_th0 |=> $stable(st.tl0) && $stable(st.th0);
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("halted timer 0 changed");  // RULE2

	property p_edge_flag;
		@(posedge MCLK) disable iff (RST)
		st.timer_control_status[`DTC_TC_XA_TYPE] && !wr_timer_control_status && xa_fall |=> EXT_IRQ_A_FLAG;
	endproperty
	a_edge_flag: assert property (p_edge_flag) else $error("edge request flag not set");  // RULE3

	property p_level_flag;
		@(posedge MCLK) disable iff (RST)
		!st.timer_control_status[`DTC_TC_XB_TYPE] && !wr_timer_control_status |=> EXT_IRQ_B_FLAG == !$past(EXT_IRQ_B_PIN);
	endproperty
	a_level_flag: assert property (p_level_flag) else $error("level flag does not follow pin");  // RULE4

	property p_gate_blocks;
		@(posedge MCLK) disable iff (RST)
		st.timer_mode_config[`DTC_TM_T1_GATE] && !xb_level && !wr_tl1 && !wr_th1 |=> $stable(st.tl1) && $stable(st.th1);
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer 1 counted");  // RULE6

	property p_t1_split_halt;
		@(posedge MCLK) disable iff (RST)
		mode1 == DTC_MODE_SPLIT && !wr_tl1 && !wr_th1 |=> $stable({st.th1, st.tl1});
	endproperty
	a_t1_split_halt: assert property (p_t1_split_halt) else $error("timer 1 moved in mode 3");  // RULE9

	property p_split_high;
		@(posedge MCLK) disable iff (RST)
		en0_high && st.th0 == 8'hff && !wr_timer_control_status && !wr_th0 |=> TIMER1_OVERFLOW_FLAG && st.th0 == 8'h00;
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high byte overflow wrong");  // RULE10

	property p_reload;
		@(posedge MCLK) disable iff (RST)
		mode0 == DTC_MODE_RELOAD && en0 && st.tl0 == 8'hff && !wr_tl0 |=> st.tl0 == $past(st.th0);
	endproperty
	a_reload: assert property (p_reload) else $error("auto reload did not copy high byte");  // RULE16

	property p_ext_count;
		@(posedge MCLK) disable iff (RST)
		st.timer_mode_config[`DTC_TM_T0_SRC] && !p0_fall && !split0 && !wr_tl0 && !wr_th0 |=> $stable(st.tl0);
	endproperty
	a_ext_count: assert property (p_ext_count) else $error("counter moved without a pin edge");  // RULE7

endmodule : dtc_timer

`default_nettype wire

// ===== verification/dtc_pin_model.sv
// Pin-side model: count pulse sources and interrupt request lines.
// Assumes the bench calls its tasks; pins change only at falling edges.
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_model (
	input  wire logic mclk,
	output logic      irq_a,
	output logic      irq_b,
	output logic      cnt0,
	output logic      cnt1
);
	// Lines rest high as if pulled up, so no request or edge at start
	initial begin
		irq_a = 1'b1;
		irq_b = 1'b1;
		cnt0 = 1'b1;
		cnt1 = 1'b1;
	end

	// Two cycles per level, twice what the pin sampler needs
	task automatic pulse(input int which, input int n);
		for (int k = 0; k < n; k++) begin
			@(negedge mclk);
			if (which == 0) cnt0 = 1'b0;
			else cnt1 = 1'b0;
			repeat (2) @(negedge mclk);
			if (which == 0) cnt0 = 1'b1;
			else cnt1 = 1'b1;
			@(negedge mclk);
		end
	endtask : pulse

	task automatic irq(input int which, input logic lvl);
		@(negedge mclk);
		if (which == 0) irq_a = lvl;
		else irq_b = lvl;
	endtask : irq
endmodule : dtc_pin_model

`default_nettype wire

// ===== verification/tb_dual_timer_counter_with_ext_irq.sv
// Self-checking bench for the dual timer/counter block.
// Assumes dtc_pkg and dtc_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_dual_timer_counter_with_ext_irq;
	import dtc_pkg::*;
	logic         mclk, rst, ack0, ack1, acka, ackb, t2sp;
	logic         pa, pb, p0, p1, of0, of1, fa, fb, t2tick;
	dtc_sfr_req_t req;
	logic [7:0]   rdata;
	int           miscompares = 0;
	int           checks = 0;

	dtc_timer DUT (.MCLK(mclk), .RST(rst), .SFR_REQ(req), .SFR_RDATA(rdata),
		.ACK_TIMER0(ack0), .ACK_TIMER1(ack1), .ACK_EXT_A(acka), .ACK_EXT_B(ackb),
		.EXT_IRQ_A_PIN(pa), .EXT_IRQ_B_PIN(pb), .TIMER0_PULSE_PIN(p0),
		.TIMER1_PULSE_PIN(p1), .TIMER2_SPECIAL_MODE(t2sp),
		.TIMER0_OVERFLOW_FLAG(of0), .TIMER1_OVERFLOW_FLAG(of1),
		.EXT_IRQ_A_FLAG(fa), .EXT_IRQ_B_FLAG(fb), .TIMER2_TICK(t2tick));
	dtc_pin_model PINS (.mclk(mclk), .irq_a(pa), .irq_b(pb), .cnt0(p0), .cnt1(p1));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask : cmp8

	task automatic cmp1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp1

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(negedge mclk);
		req.wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge mclk);
		req.rd = 1'b0;
		@(negedge mclk);
		cmp8(rdata, exp);
	endtask : rd

	task automatic ack(input int which);
		@(negedge mclk);
		{ack0, ack1, acka, ackb} = 4'b1000 >> which;
		@(negedge mclk);
		{ack0, ack1, acka, ackb} = 4'h0;
	endtask : ack

	// Run bit set for exactly n cycles, so tick counts do not hang on divider phase
	task automatic run_for(input logic [7:0] tc, input int n);
		wr(8'h88, tc);
		repeat (n - 2) @(negedge mclk);
		wr(8'h88, 8'h00);
	endtask : run_for

	task automatic t_regs();
		for (int a = 8'h88; a < 8'h8e; a++) rd(8'(a), 8'h00);
		rd(8'h8e, 8'h01);
		wr(8'h8e, 8'hff);
		rd(8'h8e, 8'h3f);
		wr(8'h89, 8'ha5);
		rd(8'h89, 8'ha5);
		wr(8'h80, 8'h5a);
		rd(8'h80, 8'h00);
	endtask : t_regs

	task automatic t_rate(input int t);
		logic [7:0] lo;
		lo = 8'h8a + 8'(t);
		wr(8'h89, t ? 8'h10 : 8'h01);
		for (int f = 0; f < 2; f++) begin
			wr(8'h8e, f ? (t ? 8'h10 : 8'h08) : 8'h00);
			wr(lo, 8'h00);
			wr(lo + 8'h02, 8'h00);
			run_for(t ? 8'h40 : 8'h10, 48);
			rd(lo, f ? 8'h0c : 8'h04);
			repeat (20) @(negedge mclk);
			rd(lo, f ? 8'h0c : 8'h04);
			rd(lo + 8'h02, 8'h00);
		end
	endtask : t_rate

	task automatic t_tick2();
		int n;
		for (int c = 0; c < 3; c++) begin
			wr(8'h8e, c == 0 ? 8'h00 : 8'h20);
			t2sp = (c == 2);
			n = 0;
			repeat (4) @(negedge mclk);
			repeat (48) begin
				@(posedge mclk);
				#1;
				if (t2tick === 1'b1)
					n++;
			end
			cmp8(8'(n), c == 1 ? 8'h0c : 8'h04);
		end
		t2sp = 1'b0;
	endtask : t_tick2

	task automatic t_ovf();
		wr(8'h89, 8'h05);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h10);
		PINS.pulse(0, 1);
		cmp1(of0, 1'b1);
		rd(8'h8a, 8'h00);
		rd(8'h8c, 8'h00);
		ack(0);
		cmp1(of0, 1'b0);
		wr(8'h89, 8'h50);
		wr(8'h8b, 8'hff);
		wr(8'h8d, 8'hff);
		wr(8'h88, 8'h40);
		PINS.pulse(1, 1);
		cmp1(of1, 1'b1);
		wr(8'h88, 8'h00);
		cmp1(of1, 1'b0);
		PINS.pulse(1, 2);
		rd(8'h8b, 8'h00);
	endtask : t_ovf

	task automatic t_modes();
		wr(8'h89, 8'h64);
		wr(8'h8a, 8'hfe);
		wr(8'h8c, 8'hff);
		wr(8'h8d, 8'h80);
		wr(8'h8b, 8'hfe);
		wr(8'h88, 8'h50);
		PINS.pulse(0, 1);
		rd(8'h8a, 8'hff);
		PINS.pulse(0, 1);
		PINS.pulse(1, 2);
		rd(8'h8a, 8'he0);
		rd(8'h8c, 8'h00);
		cmp1(of0, 1'b1);
		rd(8'h8b, 8'h80);
		rd(8'h8d, 8'h80);
		cmp1(of1, 1'b1);
		wr(8'h89, 8'h66);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'h33);
		PINS.pulse(0, 1);
		rd(8'h8a, 8'h33);
		wr(8'h88, 8'h00);
	endtask : t_modes

	task automatic t_gate();
		wr(8'h89, 8'h0d);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h10);
		PINS.irq(0, 1'b0);
		PINS.pulse(0, 2);
		rd(8'h8a, 8'h00);
		PINS.irq(0, 1'b1);
		PINS.pulse(0, 3);
		rd(8'h8a, 8'h03);
		wr(8'h88, 8'h00);
	endtask : t_gate

	task automatic t_mode3();
		wr(8'h89, 8'h30);
		wr(8'h8b, 8'h55);
		run_for(8'h40, 48);
		rd(8'h8b, 8'h55);
		wr(8'h89, 8'h07);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'h12);
		wr(8'h88, 8'h10);
		PINS.pulse(0, 1);
		rd(8'h8a, 8'h00);
		rd(8'h8c, 8'h12);
		cmp1(of0, 1'b1);
		wr(8'h8c, 8'hff);
		wr(8'h88, 8'h40);
		repeat (20) @(negedge mclk);
		cmp1(of1, 1'b1);
		wr(8'h88, 8'h00);
	endtask : t_mode3

	task automatic t_irq();
		logic [7:0] ty;
		for (int i = 0; i < 2; i++) begin
			ty = 8'h01 << (2 * i);
			wr(8'h88, ty);
			PINS.irq(i, 1'b0);
			repeat (4) @(negedge mclk);
			PINS.irq(i, 1'b1);
			repeat (3) @(negedge mclk);
			cmp1(i ? fb : fa, 1'b1);
			wr(8'h88, ty);
			cmp1(i ? fb : fa, 1'b0);
			PINS.irq(i, 1'b0);
			PINS.irq(i, 1'b1);
			repeat (4) @(negedge mclk);
			cmp1(i ? fb : fa, 1'b1);
			ack(2 + i);
			cmp1(i ? fb : fa, 1'b0);
			wr(8'h88, 8'h00);
			PINS.irq(i, 1'b0);
			repeat (3) @(negedge mclk);
			cmp1(i ? fb : fa, 1'b1);
			PINS.irq(i, 1'b1);
			repeat (3) @(negedge mclk);
			cmp1(i ? fb : fa, 1'b0);
		end
	endtask : t_irq

	initial begin
		rst = 1'b1;
		req = '0;
		{ack0, ack1, acka, ackb} = 4'h0;
		t2sp = 1'b0;
		repeat (16) @(negedge mclk);
		rst = 1'b0;
		t_regs();
		t_rate(0);
		t_rate(1);
		t_tick2();
		t_ovf();
		t_modes();
		t_gate();
		t_mode3();
		t_irq();
		tally_and_finish();
	end

	// Whole run is under a thousand cycles; this limit is twenty thousand, well beyond it
	initial begin
		#100000;
		miscompares++;
		tally_and_finish();
	end
endmodule : tb_dual_timer_counter_with_ext_irq

`default_nettype wire
